// ---- logic/mfs_pkg.sv ----
// What this block does
// R1: alert flashes as long as any monitored error persists, unless the status reading is selected
// R2: each flag clears itself when its cause goes; no manual clear exists
// R3: digit 1 general, digit 2 inlet, digit 3 outlet, digit 5 flow sensor
// R4: supply-loss bit 0 only logged, never live; low battery is bit 1
// R5: inlet over-range/open is bit 3, outlet over-range/open is bit 4
// R6: inlet under-range/short is bit 5, outlet under-range/short is bit 6
// R7: invalid inlet minus outlet difference is bit 7
// R8: flow sensor air is bit 8, reversed flow is bit 9
// R9: excess flow bit 11 only after above max flow for over one hour
// R10: code is sum of active weights, sent in bit form serially
// R11: alert flashes whenever the code is not all zero
// R12: alert stops flashing while the status reading is on the display
// R13: event counter increments by one on each code change
// R14: event counter is zero on delivery; transport state inhibits counting
// R15: log keeps the 50 most recent changes with date and code
// R16: faulty temperature reads 0.00 C below range, 185.00 C above range serially
// R17: faulty sensor reading shows three right dashes, no decimal points
// R18: any sensor error gives zero power and dashes on difference and power; here flow sensor errors dash power but not difference
// R19: flow sensor error gives zero flow serially
// R20: energy depending on a failed sensor does not accumulate
// R21: bad difference alone is no sensor error; above nominal flow is no error
// R22: each flag may be enabled or disabled by the country setting
// R23: transport state shows flags but neither logs nor counts; ends at first flow
// R24: each log entry also stores time, heat energy, cooling energy and volume
// R25: change found by comparing new code with previous once per cycle
`default_nettype none
package mfs_pkg;
	localparam int CODE_W = 16;
	localparam int BIT_SUPPLY = 0;
	localparam int BIT_LOWBAT = 1;
	localparam int BIT_IN_HI = 3;
	localparam int BIT_OUT_HI = 4;
	localparam int BIT_IN_LO = 5;
	localparam int BIT_OUT_LO = 6;
	localparam int BIT_DT = 7;
	localparam int BIT_AIR = 8;
	localparam int BIT_REV = 9;
	localparam int BIT_XFLOW = 11;
	localparam logic [CODE_W-1:0] LIVE_MASK = 16'h0bfa;
	localparam logic [CODE_W-1:0] ENABLE_RST = 16'h0bfb;
	localparam logic [15:0] TEMP_MIN = 16'h0000;
	localparam logic [15:0] TEMP_MAX = 16'h4844;
	localparam logic [3:0] DIGIT_DASH = 4'hd;
	localparam int CLK_HZ = 100_000_000;
	localparam longint XFLOW_SEC = 3600;
	localparam longint XFLOW_CYC = XFLOW_SEC * CLK_HZ;
	localparam int LOG_DEPTH = 50;
	localparam int DATE_W = 32;
	localparam int TOD_W = 24;
	localparam int ENERGY_W = 32;
	localparam int EVT_W = 16;
	localparam int DISP_SEL_W = 3;
	localparam logic [2:0] SEL_INLET = 3'h1;
	localparam logic [2:0] SEL_OUTLET = 3'h2;
	localparam logic [2:0] SEL_DIFF = 3'h3;
	localparam logic [2:0] SEL_FLOW = 3'h4;
	localparam logic [2:0] SEL_POWER = 3'h5;
	localparam logic [2:0] SEL_STATUS = 3'h6;
	localparam int FLASH_HALF_MS = 500;
	localparam int FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
	typedef enum logic [1:0] {
		MFS_TRANSPORT = 2'b01,
		MFS_ACTIVE = 2'b10
	} mfs_mode_t;
endpackage : mfs_pkg
`default_nettype wire

// ---- logic/mfs_change_log.sv ----
`default_nettype none
module mfs_change_log
	import mfs_pkg::*;
#(
	parameter int DEPTH = LOG_DEPTH
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic [DATE_W-1:0] wr_date,
	input wire logic [TOD_W-1:0] wr_tod,
	input wire logic [CODE_W-1:0] wr_code,
	input wire logic [ENERGY_W-1:0] wr_heat,
	input wire logic [ENERGY_W-1:0] wr_cool,
	input wire logic [ENERGY_W-1:0] wr_vol,
	input wire logic [5:0] rd_age,
	output logic [DATE_W-1:0] rd_date,
	output logic [TOD_W-1:0] rd_tod,
	output logic [CODE_W-1:0] rd_code,
	output logic [ENERGY_W-1:0] rd_heat,
	output logic [ENERGY_W-1:0] rd_cool,
	output logic [ENERGY_W-1:0] rd_vol,
	output logic [5:0] fill_cnt
);
	localparam int ENT_W = DATE_W + TOD_W + CODE_W + 3 * ENERGY_W;
	logic [ENT_W-1:0] mem [DEPTH];
	logic [5:0] wptr_q;
	logic [5:0] fill_q;
	logic [5:0] rd_idx;
	logic [ENT_W-1:0] rd_q;

	function automatic logic [5:0] wrap_dec(input logic [5:0] p, input logic [5:0] n);
		logic [6:0] t;
		t = {1'b0, p} + 7'(DEPTH) - {1'b0, n} - 7'h01;
		if (t >= 7'(DEPTH))
			t = t - 7'(DEPTH);
		return t[5:0];
	endfunction : wrap_dec

	// ring buffer keeps the newest entries, oldest overwritten [R15]
	always_ff @(posedge clk_sys) begin
		if (wr_en)
			mem[wptr_q] <= {wr_date, wr_tod, wr_code, wr_heat, wr_cool, wr_vol}; // [R24]
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wptr_q <= 6'h00;
			fill_q <= 6'h00;
		end else if (wr_en) begin
			wptr_q <= (wptr_q == 6'(DEPTH - 1)) ? 6'h00 : wptr_q + 6'h01;
			if (fill_q != 6'(DEPTH))
				fill_q <= fill_q + 6'h01;
		end
	end

	// age 0 is the latest change
	assign rd_idx = wrap_dec(wptr_q, (rd_age >= 6'(DEPTH)) ? 6'(DEPTH - 1) : rd_age);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			rd_q <= '0;
		else if (rd_age < fill_q)
			rd_q <= mem[rd_idx];
		else
			rd_q <= '0;
	end

	assign {rd_date, rd_tod, rd_code, rd_heat, rd_cool, rd_vol} = rd_q;
	assign fill_cnt = fill_q;
endmodule : mfs_change_log
`default_nettype wire

// ---- logic/mfs_status.sv ----
// The placing of the registers and the APB register port were chosen for this implementation.
`default_nettype none
module mfs_status
	import mfs_pkg::*;
#(
	parameter longint XFLOW_CYCLES = XFLOW_CYC,
	parameter int FLASH_CYCLES = FLASH_HALF_CYC
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic pclk_unused,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic supply_lost,
	input wire logic low_battery,
	input wire logic inlet_temp_sensor_hi,
	input wire logic inlet_temp_sensor_lo,
	input wire logic outlet_temp_sensor_hi,
	input wire logic outlet_temp_sensor_lo,
	input wire logic dt_invalid,
	input wire logic flow_sensor_air,
	input wire logic flow_sensor_reverse,
	input wire logic above_max_approved_flow,
	input wire logic above_nominal_flow,
	input wire logic flow_registered,
	input wire logic [15:0] inlet_temp_raw,
	input wire logic [15:0] outlet_temp_raw,
	input wire logic [31:0] flow_raw,
	input wire logic [31:0] power_raw,
	input wire logic [DATE_W-1:0] date_now,
	input wire logic [TOD_W-1:0] tod_now,
	input wire logic [ENERGY_W-1:0] heat_energy,
	input wire logic [ENERGY_W-1:0] cool_energy,
	input wire logic [ENERGY_W-1:0] volume,
	input wire logic [DISP_SEL_W-1:0] disp_sel,
	output logic alert_on,
	output logic [CODE_W-1:0] status_code,
	output logic [15:0] inlet_temp_ser,
	output logic [15:0] outlet_temp_ser,
	output logic [31:0] flow_ser,
	output logic [31:0] power_ser,
	output logic disp_dash,
	output logic heat_accum_en,
	output logic cool_accum_en,
	output logic volume_accum_en
);
	localparam logic [7:0] A_CODE = 8'h00;
	localparam logic [7:0] A_ENABLE = 8'h04;
	localparam logic [7:0] A_EVENTS = 8'h08;
	localparam logic [7:0] A_MODE = 8'h0c;
	localparam logic [7:0] A_LOGSEL = 8'h10;
	localparam logic [7:0] A_LOGCODE = 8'h14;
	localparam logic [7:0] A_LOGDATE = 8'h18;
	localparam logic [7:0] A_LOGTOD = 8'h1c;
	localparam logic [7:0] A_LOGHEAT = 8'h20;
	localparam logic [7:0] A_LOGCOOL = 8'h24;
	localparam logic [7:0] A_LOGVOL = 8'h28;

	logic [CODE_W-1:0] enable_q;
	logic [CODE_W-1:0] raw_code;
	logic [CODE_W-1:0] full_code;
	logic [CODE_W-1:0] code_q;
	logic [CODE_W-1:0] logged_q;
	logic [EVT_W-1:0] events_q;
	mfs_mode_t mode_q;
	logic [5:0] logsel_q;
	logic [41:0] xflow_cnt_q;
	logic xflow_q;
	logic [31:0] flash_cnt_q;
	logic flash_q;
	logic change;
	logic temp_err;
	logic flow_err;
	logic log_wr;
	logic [DATE_W-1:0] l_date;
	logic [TOD_W-1:0] l_tod;
	logic [CODE_W-1:0] l_code;
	logic [ENERGY_W-1:0] l_heat;
	logic [ENERGY_W-1:0] l_cool;
	logic [ENERGY_W-1:0] l_vol;
	logic [5:0] l_fill;
	logic [31:0] rdata;
	logic bus_wr;

	function automatic logic [CODE_W-1:0] bitw(input int pos, input logic v);
		logic [CODE_W-1:0] r;
		r = '0;
		r[pos] = v;
		return r;
	endfunction : bitw

	// excess flow needs an unbroken hour above the max flow [R9]
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			xflow_cnt_q <= '0;
			xflow_q <= 1'b0;
		end else if (!above_max_approved_flow) begin
			xflow_cnt_q <= '0;
			xflow_q <= 1'b0;
		end else if (xflow_cnt_q < 42'(XFLOW_CYCLES)) begin
			xflow_cnt_q <= xflow_cnt_q + 42'h1;
		end else begin
			xflow_q <= 1'b1;
		end
	end

	// flags are sums of weights, each pure combinational of its cause except the registered excess flow bit [R2] [R10]
	always_comb begin
		raw_code = bitw(BIT_SUPPLY, supply_lost)
			| bitw(BIT_LOWBAT, low_battery) // [R3] [R4]
			| bitw(BIT_IN_HI, inlet_temp_sensor_hi) // [R5]
			| bitw(BIT_OUT_HI, outlet_temp_sensor_hi) // [R5]
			| bitw(BIT_IN_LO, inlet_temp_sensor_lo) // [R6]
			| bitw(BIT_OUT_LO, outlet_temp_sensor_lo) // [R6]
			| bitw(BIT_DT, dt_invalid) // [R7]
			| bitw(BIT_AIR, flow_sensor_air) // [R8]
			| bitw(BIT_REV, flow_sensor_reverse) // [R8]
			| bitw(BIT_XFLOW, xflow_q); // [R9]
		full_code = raw_code & enable_q; // [R22]
	end

	// registered live code hides the supply bit [R4]
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			code_q <= '0;
			logged_q <= '0;
		end else begin
			code_q <= full_code & LIVE_MASK;
			logged_q <= full_code;
		end
	end
	assign status_code = code_q;

	assign change = (full_code != logged_q); // [R25]

	// transport state ends at first registered flow [R23]
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			mode_q <= MFS_TRANSPORT;
		else if (mode_q == MFS_TRANSPORT && flow_registered)
			mode_q <= MFS_ACTIVE;
	end

	assign log_wr = change && mode_q == MFS_ACTIVE; // [R23]

	// counts from zero only once active [R13] [R14]
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			events_q <= '0;
		else if (log_wr)
			events_q <= events_q + EVT_W'(1);
	end

	mfs_change_log #(
		.DEPTH(LOG_DEPTH)
	) u_log (
		.clk_sys(clk_sys),
		.reset(reset),
		.wr_en(log_wr), // [R15]
		.wr_date(date_now),
		.wr_tod(tod_now), // [R24]
		.wr_code(full_code),
		.wr_heat(heat_energy),
		.wr_cool(cool_energy),
		.wr_vol(volume),
		.rd_age(logsel_q),
		.rd_date(l_date),
		.rd_tod(l_tod),
		.rd_code(l_code),
		.rd_heat(l_heat),
		.rd_cool(l_cool),
		.rd_vol(l_vol),
		.fill_cnt(l_fill)
	);

	// flashing alert
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			flash_cnt_q <= '0;
			flash_q <= 1'b0;
		end else if (flash_cnt_q >= 32'(FLASH_CYCLES - 1)) begin
			flash_cnt_q <= '0;
			flash_q <= ~flash_q;
		end else begin
			flash_cnt_q <= flash_cnt_q + 32'h1;
		end
	end

	// any nonzero live code flashes, except on the status reading [R1] [R11] [R12]
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			alert_on <= 1'b0;
		else
			alert_on <= (full_code & LIVE_MASK) != '0 && disp_sel != SEL_STATUS && flash_q;
	end

	// sensor errors; bad difference and high nominal flow excluded [R21]
	assign temp_err = inlet_temp_sensor_hi | inlet_temp_sensor_lo
		| outlet_temp_sensor_hi | outlet_temp_sensor_lo;
	assign flow_err = flow_sensor_air | flow_sensor_reverse;

	// safe serial values
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			inlet_temp_ser <= '0;
			outlet_temp_ser <= '0;
			flow_ser <= '0;
			power_ser <= '0;
			disp_dash <= 1'b0;
		end else begin
			if (inlet_temp_sensor_lo)
				inlet_temp_ser <= TEMP_MIN; // [R16]
			else if (inlet_temp_sensor_hi)
				inlet_temp_ser <= TEMP_MAX; // [R16]
			else
				inlet_temp_ser <= inlet_temp_raw;
			if (outlet_temp_sensor_lo)
				outlet_temp_ser <= TEMP_MIN; // [R16]
			else if (outlet_temp_sensor_hi)
				outlet_temp_ser <= TEMP_MAX; // [R16]
			else
				outlet_temp_ser <= outlet_temp_raw;
			flow_ser <= flow_err ? 32'h0 : flow_raw; // [R19]
			power_ser <= (temp_err || flow_err) ? 32'h0 : power_raw; // [R18]
			// selected reading blanked to dashes without decimals [R17] [R18]
			if (disp_sel == SEL_INLET)
				disp_dash <= inlet_temp_sensor_hi | inlet_temp_sensor_lo;
			else if (disp_sel == SEL_OUTLET)
				disp_dash <= outlet_temp_sensor_hi | outlet_temp_sensor_lo;
			else if (disp_sel == SEL_DIFF)
				disp_dash <= temp_err;
			else if (disp_sel == SEL_FLOW)
				disp_dash <= flow_err;
			else if (disp_sel == SEL_POWER)
				disp_dash <= temp_err | flow_err;
			else
				disp_dash <= 1'b0;
		end
	end

	// energy stops on failed sensors, volume only on flow errors [R20]
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			heat_accum_en <= 1'b0;
			cool_accum_en <= 1'b0;
			volume_accum_en <= 1'b0;
		end else begin
			heat_accum_en <= !(temp_err || flow_err);
			cool_accum_en <= !(temp_err || flow_err);
			volume_accum_en <= !flow_err;
		end
	end

	// apb slave, zero wait states
	assign pready = 1'b1;
	assign bus_wr = psel && penable && pwrite;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			enable_q <= ENABLE_RST;
			logsel_q <= '0;
		end else if (bus_wr) begin
			if (paddr == A_ENABLE)
				enable_q <= pwdata[CODE_W-1:0] & ENABLE_RST; // [R22]
			else if (paddr == A_LOGSEL)
				logsel_q <= pwdata[5:0];
		end
	end

	always_comb begin
		rdata = 32'h0;
		if (paddr == A_CODE)
			rdata = {16'h0, code_q}; // [R10]
		else if (paddr == A_ENABLE)
			rdata = {16'h0, enable_q};
		else if (paddr == A_EVENTS)
			rdata = {16'h0, events_q};
		else if (paddr == A_MODE)
			rdata = {24'h0, l_fill, 1'b0, mode_q == MFS_TRANSPORT};
		else if (paddr == A_LOGSEL)
			rdata = {26'h0, logsel_q};
		else if (paddr == A_LOGCODE)
			rdata = {16'h0, l_code};
		else if (paddr == A_LOGDATE)
			rdata = l_date;
		else if (paddr == A_LOGTOD)
			rdata = {8'h0, l_tod};
		else if (paddr == A_LOGHEAT)
			rdata = l_heat;
		else if (paddr == A_LOGCOOL)
			rdata = l_cool;
		else if (paddr == A_LOGVOL)
			rdata = l_vol;
	end

	assign prdata = rdata;
	assign pslverr = psel && penable && paddr > A_LOGVOL;
endmodule : mfs_status
`default_nettype wire

// ---- dv/mfs_status_props.sv ----
`default_nettype none
module mfs_status_props
	import mfs_pkg::*;
#(
	parameter longint XFLOW_CYCLES = XFLOW_CYC,
	parameter int FLASH_CYCLES = FLASH_HALF_CYC
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic inlet_temp_sensor_hi,
	input wire logic inlet_temp_sensor_lo,
	input wire logic outlet_temp_sensor_hi,
	input wire logic outlet_temp_sensor_lo,
	input wire logic dt_invalid,
	input wire logic flow_sensor_air,
	input wire logic flow_sensor_reverse,
	input wire logic above_max_approved_flow,
	input wire logic [DISP_SEL_W-1:0] disp_sel,
	input wire logic alert_on,
	input wire logic [CODE_W-1:0] status_code,
	input wire logic [15:0] inlet_temp_ser,
	input wire logic [15:0] outlet_temp_ser,
	input wire logic [31:0] flow_ser,
	input wire logic [31:0] power_ser,
	input wire logic heat_accum_en,
	input wire logic cool_accum_en
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic [6:0] cz;
	logic terr;
	logic [39:0] xcnt_q;
	assign cz = {flow_sensor_reverse, flow_sensor_air, dt_invalid, outlet_temp_sensor_lo,
		inlet_temp_sensor_lo, outlet_temp_sensor_hi, inlet_temp_sensor_hi};
	assign terr = inlet_temp_sensor_hi | inlet_temp_sensor_lo | outlet_temp_sensor_hi
		| outlet_temp_sensor_lo;
	// consecutive cycles with flow above the approved maximum
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			xcnt_q <= '0;
		end else if (!above_max_approved_flow) begin
			xcnt_q <= '0;
		end else if (xcnt_q <= XFLOW_CYCLES) begin
			xcnt_q <= xcnt_q + 40'h1;
		end
	end
	code_bits_a: assert property (status_code[10:2] == {1'b0, $past(cz), 1'b0})
		else $error("status code bits wrong");
	supply_hidden_a: assert property (status_code[BIT_SUPPLY] == 1'b0)
		else $error("supply bit in live code");
	xflow_wait_a: assert property (status_code[BIT_XFLOW] |-> $past(xcnt_q) > XFLOW_CYCLES)
		else $error("excess flow set too early");
	xflow_clear_a: assert property (!$past(above_max_approved_flow, 2)
		|-> !status_code[BIT_XFLOW])
		else $error("excess flow not cleared");
	alert_idle_a: assert property ((status_code == 16'h0 && $past(status_code) == 16'h0)
		|-> !alert_on)
		else $error("alert with zero code");
	alert_dark_a: assert property ((disp_sel == SEL_STATUS && $past(disp_sel) == SEL_STATUS)
		|-> !alert_on)
		else $error("alert while status shown");
	alert_flash_a: assert property (not ((status_code != 16'h0 && disp_sel != SEL_STATUS
		&& !alert_on) [*8]))
		else $error("alert not flashing");
	temp_max_a: assert property ($past(inlet_temp_sensor_hi) |-> inlet_temp_ser == TEMP_MAX)
		else $error("inlet high value wrong");
	temp_min_a: assert property ($past(outlet_temp_sensor_lo) |-> outlet_temp_ser == TEMP_MIN)
		else $error("outlet low value wrong");
	flow_zero_a: assert property ($past(flow_sensor_air || flow_sensor_reverse)
		|-> flow_ser == 32'h0 && power_ser == 32'h0)
		else $error("flow or power not zero");
	heat_stop_a: assert property ($past(terr) |-> !heat_accum_en && !cool_accum_en
		&& power_ser == 32'h0)
		else $error("energy runs on sensor error");
endmodule : mfs_status_props
bind mfs_status mfs_status_props #(.XFLOW_CYCLES(XFLOW_CYCLES), .FLASH_CYCLES(FLASH_CYCLES))
	u_props (.clk_sys, .reset, .inlet_temp_sensor_hi, .inlet_temp_sensor_lo,
	.outlet_temp_sensor_hi, .outlet_temp_sensor_lo, .dt_invalid, .flow_sensor_air,
	.flow_sensor_reverse, .above_max_approved_flow, .disp_sel, .alert_on, .status_code,
	.inlet_temp_ser, .outlet_temp_ser, .flow_ser, .power_ser, .heat_accum_en, .cool_accum_en);
`default_nettype wire

// ---- dv/mfs_reader.sv ----
`default_nettype none
module mfs_reader (
	input wire logic clk_sys,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// one apb transfer, held until pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) begin
			@(posedge clk_sys);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~wd;
	endtask : xfer
endmodule : mfs_reader
`default_nettype wire

// ---- dv/mfs_status_tb.sv ----
`default_nettype none
module mfs_status_tb
	import mfs_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [9:0] cz = '0;
	logic nomf = 1'b0, flowreg = 1'b0, er;
	logic [2:0] sel = SEL_INLET;
	logic [31:0] tk = 32'h0, rv, prdata, pwdata, fs, ps;
	logic psel, penable, pwrite, pready, pslverr, alert_on, dash, hae, cae, vae;
	logic [7:0] paddr;
	logic [15:0] code, its, ots;
	int err_count = 0, checks_done = 0, n;
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) tk <= tk + 32'h1;
	mfs_reader rdr (.clk_sys, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
		.pwdata);
	mfs_status #(.XFLOW_CYCLES(20), .FLASH_CYCLES(4)) dut (.clk_sys, .reset,
		.pclk_unused(1'b0), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .supply_lost(cz[0]), .low_battery(cz[1]), .inlet_temp_sensor_hi(cz[2]),
		.outlet_temp_sensor_hi(cz[3]), .inlet_temp_sensor_lo(cz[4]),
		.outlet_temp_sensor_lo(cz[5]), .dt_invalid(cz[6]), .flow_sensor_air(cz[7]),
		.flow_sensor_reverse(cz[8]), .above_max_approved_flow(cz[9]),
		.above_nominal_flow(nomf), .flow_registered(flowreg), .inlet_temp_raw(tk[15:0]),
		.outlet_temp_raw(tk[31:16]), .flow_raw(tk), .power_raw(~tk), .date_now(tk),
		.tod_now(tk[23:0]), .heat_energy(tk), .cool_energy(~tk), .volume(tk),
		.disp_sel(sel), .alert_on, .status_code(code), .inlet_temp_ser(its),
		.outlet_temp_ser(ots), .flow_ser(fs), .power_ser(ps), .disp_dash(dash),
		.heat_accum_en(hae), .cool_accum_en(cae), .volume_accum_en(vae));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a);
		rdr.xfer(1'b0, a, 32'h0, rv, er);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		rdr.xfer(1'b1, a, d, rv, er);
	endtask : wr
	task automatic set(input logic [9:0] v);
		@(posedge clk_sys);
		cz <= v;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : set
	task automatic dsel(input logic [2:0] s);
		@(posedge clk_sys);
		sel <= s;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : dsel
	task automatic alert_wait();
		n = 0;
		while (alert_on !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
	endtask : alert_wait
	task automatic t_reset();
		rd(8'h08);
		chk("events", 32'h0, rv);
		rd(8'h0c);
		chk("transport", 32'h1, {31'h0, rv[0]});
		rd(8'h04);
		chk("enable", 32'h0bfb, rv);
		$display("test reset done");
	endtask : t_reset
	task automatic t_codes();
		logic [15:0] w [9] = '{16'h1, 16'h2, 16'h8, 16'h10, 16'h20, 16'h40, 16'h80, 16'h100,
			16'h200};
		for (int i = 0; i < 9; i++) begin
			set(10'h1 << i);
			chk("code", {16'h0, w[i] & 16'hfffe}, {16'h0, code});
		end
		set(10'h1e6);
		chk("sum", 32'h3ca, {16'h0, code});
		chk("t in", {16'h0, TEMP_MAX}, {16'h0, its});
		chk("t out", {16'h0, TEMP_MIN}, {16'h0, ots});
		chk("flow", 32'h0, fs);
		chk("dash", 32'h1, {31'h0, dash});
		chk("heat en", 32'h0, {31'h0, hae});
		chk("vol en", 32'h0, {31'h0, vae});
		chk("power", 32'h0, ps);
		dsel(SEL_OUTLET);
		chk("dash out", 32'h1, {31'h0, dash});
		dsel(SEL_DIFF);
		chk("dash diff", 32'h1, {31'h0, dash});
		dsel(SEL_POWER);
		chk("dash power", 32'h1, {31'h0, dash});
		dsel(SEL_INLET);
		@(posedge clk_sys);
		nomf <= 1'b1;
		set(10'h040);
		chk("dt only", 32'h80, {16'h0, code});
		chk("heat en", 32'h1, {31'h0, hae});
		chk("vol en", 32'h1, {31'h0, vae});
		chk("no dash", 32'h0, {31'h0, dash});
		@(posedge clk_sys);
		nomf <= 1'b0;
		set(10'h0);
		chk("clear", 32'h0, {16'h0, code});
		$display("test codes done");
	endtask : t_codes
	task automatic t_mask();
		wr(8'h04, 32'h0bf9);
		wr(8'h00, 32'hffff);
		set(10'h2);
		chk("masked", 32'h0, {16'h0, code});
		wr(8'h04, 32'hffff);
		set(10'h2);
		chk("unmasked", 32'h2, {16'h0, code});
		rd(8'h04);
		chk("enable", 32'h0bfb, rv);
		rd(8'h40);
		chk("unmapped", 32'h1, {rv[30:0], er});
		set(10'h0);
		$display("test mask done");
	endtask : t_mask
	task automatic t_xflow();
		@(posedge clk_sys);
		cz <= 10'h200;
		repeat (21) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("early", 32'h0, {16'h0, code});
		n = 0;
		while (code[BIT_XFLOW] !== 1'b1 && n < 12) begin
			@(negedge clk_sys);
			n++;
		end
		chk("xflow", 32'h800, {16'h0, code});
		chk("xflow time", 32'h1, n);
		set(10'h0);
		chk("xflow off", 32'h0, {16'h0, code});
		$display("test xflow done");
	endtask : t_xflow
	task automatic t_alert();
		set(10'h2);
		alert_wait();
		chk("alert", 32'h1, {31'h0, alert_on});
		dsel(SEL_STATUS);
		n = 0;
		repeat (12) begin
			@(negedge clk_sys);
			n += int'(alert_on !== 1'b0);
		end
		chk("dark", 32'h0, n);
		dsel(SEL_FLOW);
		alert_wait();
		chk("alert", 32'h1, {31'h0, alert_on});
		set(10'h0);
		chk("alert off", 32'h0, {31'h0, alert_on});
		$display("test alert done");
	endtask : t_alert
	task automatic t_events();
		logic [31:0] ex [5] = '{32'h0, 32'h1, 32'h0, 32'h2, 32'h0};
		rd(8'h08);
		chk("events", 32'h0, rv);
		flowreg <= 1'b1;
		@(posedge clk_sys);
		flowreg <= 1'b0;
		rd(8'h0c);
		chk("active", 32'h0, {31'h0, rv[0]});
		set(10'h2);
		set(10'h0);
		set(10'h1);
		set(10'h0);
		rd(8'h08);
		chk("events", 32'h4, rv);
		rd(8'h0c);
		chk("fill", 32'h4, {26'h0, rv[7:2]});
		for (int i = 0; i < 5; i++) begin
			wr(8'h10, 32'(i));
			rd(8'h14);
			chk("log code", ex[i], rv);
		end
		$display("test events done");
	endtask : t_events
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		#100000;
		err_count++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset();
		t_codes();
		t_mask();
		t_xflow();
		t_alert();
		t_events();
		stop_test();
	end
endmodule : mfs_status_tb
`default_nettype wire
